//--- rtl/lpmc_defines.svh
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

// Register byte offsets.
`define LPMC_OFF_CONTROL     4'h0
`define LPMC_OFF_STATUS      4'h4
`define LPMC_OFF_FIFO_ADDR   4'h8
`define LPMC_OFF_FIFO_DATA   4'hc

// Control register field positions.
`define LPMC_BIT_ENABLE      0
`define LPMC_BIT_DEPTH_LO    1
`define LPMC_BIT_DEPTH_HI    3
`define LPMC_BIT_MONO        4
`define LPMC_BIT_TFT         5
`define LPMC_BIT_MONO8       6
`define LPMC_BIT_DUAL        7
`define LPMC_BIT_SWAP        8
`define LPMC_BIT_POWER       11
`define LPMC_BIT_VCOMP_LO    12
`define LPMC_BIT_VCOMP_HI    13
`define LPMC_BIT_FIFO_TEST   15
`define LPMC_BIT_WATERMARK   16

// Writable bits of the control register; reserved positions read as zero.
`define LPMC_CONTROL_MASK    32'h0001b9ff
`define LPMC_CONTROL_RESET   32'h00000000

// DMA FIFO geometry and request thresholds (empty locations).
`define LPMC_FIFO_DEPTH      16
`define LPMC_FIFO_AW         4
`define LPMC_WM_LOW          5'h04
`define LPMC_WM_HIGH         5'h08

`endif

//--- rtl/lpmc_pkg.sv
package lpmc_pkg;

  typedef enum logic [1:0] {
    LPMC_VC_VSYNC,
    LPMC_VC_BACK_PORCH,
    LPMC_VC_ACTIVE,
    LPMC_VC_FRONT_PORCH
  } lpmc_vregion_t;

  typedef struct packed {
    logic          watermark;
    logic          fifo_ram_test_enable;
    lpmc_vregion_t vertical_compare_select;
    logic          panel_power_bit;
    logic          colour_order_swap;
    logic          dual_panel_select;
    logic          mono_width_eight;
    logic          panel_type_select;
    logic          stn_monochrome_select;
    logic [2:0]    pixel_depth_code;
    logic          controller_enable_bit;
  } lpmc_ctrl_t;

endpackage

//--- rtl/lpmc_cfg_if.sv
`timescale 1ns/1ns
// Control fields carried from the register bank to the mode decoder, decoded mode carried back.
interface lpmc_cfg_if;
  import lpmc_pkg::*;
  lpmc_ctrl_t ctrl;
  logic [4:0] bits_per_pixel;
  logic       depth_reserved;
  logic       mode_conflict;

  modport bank (output ctrl, input bits_per_pixel, input depth_reserved, input mode_conflict);
  modport dec  (input ctrl, output bits_per_pixel, output depth_reserved, output mode_conflict);
endinterface

//--- rtl/lpmc_mode_decode.sv
`timescale 1ns/1ns
module lpmc_mode_decode (
  lpmc_cfg_if.dec cfg  // Control fields in, decoded mode out
);
  import lpmc_pkg::*;

  function automatic logic [4:0] lpmc_bpp(input logic [2:0] code);
    unique case (code)
      3'h0:    lpmc_bpp = 5'h01;
      3'h1:    lpmc_bpp = 5'h02;
      3'h2:    lpmc_bpp = 5'h04;
      3'h3:    lpmc_bpp = 5'h08;
      3'h4:    lpmc_bpp = 5'h0c;
      default: lpmc_bpp = 5'h00;
    endcase
  endfunction

  assign cfg.bits_per_pixel = lpmc_bpp(cfg.ctrl.pixel_depth_code);
  assign cfg.depth_reserved = (cfg.ctrl.pixel_depth_code > 3'h4);
  // Dual panel without monochrome STN is undefined; flagged, not corrected.
  assign cfg.mode_conflict  = cfg.ctrl.dual_panel_select & ~cfg.ctrl.stn_monochrome_select;
endmodule // lpmc_mode_decode

//--- rtl/lpmc_fifo_ram.sv
`timescale 1ns/1ns
`include "lpmc_defines.svh"
module lpmc_fifo_ram (
  input  wire logic                     clk,    // System clock
  input  wire logic                     we,     // Write strobe
  input  wire logic [`LPMC_FIFO_AW-1:0] waddr,  // Write address
  input  wire logic [31:0]              wdata,  // Write data
  input  wire logic [`LPMC_FIFO_AW-1:0] raddr,  // Read address
  output logic      [31:0]              rdata   // Read data, one cycle later
);
  logic [31:0] mem [0:`LPMC_FIFO_DEPTH-1];

  // No reset on the array so it maps onto RAM.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // lpmc_fifo_ram

//--- rtl/lpmc_control.sv
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "lpmc_defines.svh"

//------------------------------------------------------------------------------
// Panel mode and control register bank
//------------------------------------------------------------------------------

// Overview of operation
// - Watermark bit picks four or eight empty.
// - Test bit opens FIFO RAM to software.
// - Two-bit field picks vertical compare region.
// - Power pin high only with power and enable.
// - Swap bit exchanges red and blue.
// - Dual bit selects dual-panel STN operation.
// - Mono width bit picks eight or four.
// - Type bit selects TFT, bypassing grayscaler.
// - Monochrome bit selects mono or colour STN.
// - Depth code decodes to bits per pixel.
// - Controller and panel signals run when enabled.
// - Reserved bits read zero, written zero.
module lpmc_control (
  input  wire logic                      clk,                 // System clock, 10 MHz
  input  wire logic                      resetn,              // Async reset, active low
  input  wire logic [3:0]                avs_address,         // Byte address
  input  wire logic                      avs_read,            // Read request
  input  wire logic                      avs_write,           // Write request
  input  wire logic [31:0]               avs_writedata,       // Write data
  input  wire logic [3:0]                avs_byteenable,      // Byte lanes
  output logic      [31:0]               avs_readdata,        // Read data
  output logic                           avs_waitrequest,     // Stall
  output logic      [1:0]                avs_response,        // 00 ok, 10 slave error
  input  wire logic [4:0]                fifo_upper_empty,    // Empty slots, upper FIFO
  input  wire logic [4:0]                fifo_lower_empty,    // Empty slots, lower FIFO
  output logic                           dma_request,         // Refill request
  input  wire logic                      vregion_start,       // Pulse at each region start
  input  wire lpmc_pkg::lpmc_vregion_t   vregion_now,         // Region being entered
  output logic                           vertical_compare_event, // One-cycle event pulse
  output logic                           panel_power_pin,     // Panel supply enable
  output logic                           controller_enable,   // Timing and panel logic run
  output logic                           colour_order_swap,   // Red and blue swapped
  output logic                           dual_panel,          // Dual-panel STN in use
  output logic                           mono_eight_bit,      // Mono STN 8-bit interface
  output logic                           panel_is_tft,        // TFT, grayscaler bypassed
  output logic                           grayscaler_enable,   // STN path via grayscaler
  output logic                           stn_monochrome,      // STN monochrome
  output logic      [4:0]                bits_per_pixel,      // Decoded depth, 0 if reserved
  output logic                           fetch_16bit,         // 12 bpp fetched as 16-bit words
  output logic                           mode_error           // Undefined mode programmed
);
  import lpmc_pkg::*;

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    lpmc_ctrl_t                ctrl;
    logic                      rd_pending;
    logic [`LPMC_FIFO_AW-1:0]  fifo_ptr;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                resp;
    logic                      dma_req;
    logic                      vc_pulse;
    logic                      power;
    logic [4:0]                bpp;
    logic                      mode_err;
  } lpmc_state_t;

  lpmc_state_t state;
  lpmc_state_t next_state;

  lpmc_cfg_if cfg ();
  assign cfg.ctrl = state.ctrl;

  lpmc_mode_decode u_decode (
    .cfg (cfg)
  );

  //----------------------------------------------------------------------------
  // FIFO test RAM
  //----------------------------------------------------------------------------
  logic        is_write;
  logic        is_read;
  logic        ram_we;
  logic [31:0] ram_rdata;
  logic [31:0] ctrl_word;
  logic [31:0] wmask;

  function automatic logic [31:0] lpmc_lane_mask(input logic [3:0] be);
    lpmc_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Reserved positions have no storage, so a written one is simply dropped.
  function automatic lpmc_ctrl_t lpmc_ctrl_unpack(input logic [31:0] w);
    lpmc_ctrl_t c;
    c.watermark               = w[`LPMC_BIT_WATERMARK];
    c.fifo_ram_test_enable    = w[`LPMC_BIT_FIFO_TEST];
    c.vertical_compare_select = lpmc_vregion_t'(w[`LPMC_BIT_VCOMP_HI:`LPMC_BIT_VCOMP_LO]);
    c.panel_power_bit         = w[`LPMC_BIT_POWER];
    c.colour_order_swap       = w[`LPMC_BIT_SWAP];
    c.dual_panel_select       = w[`LPMC_BIT_DUAL];
    c.mono_width_eight        = w[`LPMC_BIT_MONO8];
    c.panel_type_select       = w[`LPMC_BIT_TFT];
    c.stn_monochrome_select   = w[`LPMC_BIT_MONO];
    c.pixel_depth_code        = w[`LPMC_BIT_DEPTH_HI:`LPMC_BIT_DEPTH_LO];
    c.controller_enable_bit   = w[`LPMC_BIT_ENABLE];
    return c;
  endfunction

  assign is_write = avs_write & ~state.rvalid;
  assign is_read  = avs_read & ~state.rvalid;
  // Access stays closed unless test mode is on; software keeps the controller off then.
  assign ram_we   = is_write & (avs_address == `LPMC_OFF_FIFO_DATA)
                  & state.ctrl.fifo_ram_test_enable;
  // The struct has no room for the reserved positions, so each field is placed by hand.
  assign ctrl_word = {15'h0000, state.ctrl.watermark, state.ctrl.fifo_ram_test_enable, 1'b0,
                      state.ctrl.vertical_compare_select, state.ctrl.panel_power_bit, 2'h0,
                      state.ctrl.colour_order_swap, state.ctrl.dual_panel_select,
                      state.ctrl.mono_width_eight, state.ctrl.panel_type_select,
                      state.ctrl.stn_monochrome_select, state.ctrl.pixel_depth_code,
                      state.ctrl.controller_enable_bit} & `LPMC_CONTROL_MASK;
  assign wmask     = lpmc_lane_mask(avs_byteenable);

  lpmc_fifo_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .waddr (state.fifo_ptr),
    .wdata (avs_writedata),
    .raddr (state.fifo_ptr),
    .rdata (ram_rdata)
  );

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  logic [31:0] merged;
  logic [4:0]  threshold;

  always_comb begin
    next_state = state;
    merged     = (ctrl_word & ~wmask) | (avs_writedata & wmask);
    threshold  = state.ctrl.watermark ? `LPMC_WM_HIGH : `LPMC_WM_LOW;

    next_state.rvalid     = 1'b0;
    next_state.rd_pending = 1'b0;
    if (is_write) begin
      next_state.rvalid = 1'b1;
      next_state.resp   = 2'h0;
      unique case (avs_address)
        `LPMC_OFF_CONTROL: begin
          next_state.ctrl = lpmc_ctrl_unpack(merged);
        end
        `LPMC_OFF_FIFO_ADDR: begin
          next_state.fifo_ptr = avs_writedata[`LPMC_FIFO_AW-1:0];
        end
        `LPMC_OFF_FIFO_DATA: begin
          if (state.ctrl.fifo_ram_test_enable) begin
            next_state.fifo_ptr = state.fifo_ptr + 1'b1;
          end else begin
            next_state.resp = 2'h2;
          end
        end
        `LPMC_OFF_STATUS: ;
        default: next_state.resp = 2'h2;
      endcase
    end else if (is_read && !state.rd_pending && avs_address == `LPMC_OFF_FIFO_DATA
                 && state.ctrl.fifo_ram_test_enable) begin
      // RAM read takes one extra cycle to land.
      next_state.rd_pending = 1'b1;
    end else if (is_read) begin
      next_state.rvalid = 1'b1;
      next_state.resp   = 2'h0;
      next_state.rdata  = 32'h00000000;
      unique case (avs_address)
        `LPMC_OFF_CONTROL:   next_state.rdata = ctrl_word;
        `LPMC_OFF_STATUS:    next_state.rdata = {25'h0000000, state.mode_err,
                                                 state.dma_req, state.power,
                                                 cfg.depth_reserved, state.bpp[2:0]};
        `LPMC_OFF_FIFO_ADDR: next_state.rdata = {28'h0000000, state.fifo_ptr};
        `LPMC_OFF_FIFO_DATA: begin
          if (state.rd_pending) begin
            next_state.rdata    = ram_rdata;
            next_state.fifo_ptr = state.fifo_ptr + 1'b1;
          end else begin
            next_state.resp = 2'h2;
          end
        end
        default: next_state.resp = 2'h2;
      endcase
    end

    // Refill requests stop while the controller is off or the RAM is under test.
    next_state.dma_req = state.ctrl.controller_enable_bit
                       & ~state.ctrl.fifo_ram_test_enable
                       & ((fifo_upper_empty >= threshold)
                       | (fifo_lower_empty >= threshold));
    next_state.vc_pulse = state.ctrl.controller_enable_bit & vregion_start
                        & (vregion_now == state.ctrl.vertical_compare_select);
    // Supply follows both bits; sequencing delay is software's job.
    next_state.power = state.ctrl.panel_power_bit
                     & state.ctrl.controller_enable_bit;
    next_state.bpp      = cfg.bits_per_pixel;
    next_state.mode_err = cfg.mode_conflict | cfg.depth_reserved;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~state.rvalid;
  assign avs_readdata    = state.rdata;
  assign avs_response    = state.resp;

  assign dma_request            = state.dma_req;
  assign vertical_compare_event = state.vc_pulse;
  assign panel_power_pin        = state.power;
  assign controller_enable      = state.ctrl.controller_enable_bit;
  assign colour_order_swap      = state.ctrl.colour_order_swap;
  assign dual_panel             = state.ctrl.dual_panel_select;
  assign mono_eight_bit         = state.ctrl.mono_width_eight
                                & state.ctrl.stn_monochrome_select
                                & ~state.ctrl.panel_type_select;
  assign panel_is_tft           = state.ctrl.panel_type_select;
  assign grayscaler_enable      = ~state.ctrl.panel_type_select;
  assign stn_monochrome         = state.ctrl.stn_monochrome_select;
  assign bits_per_pixel         = state.bpp;
  assign fetch_16bit            = (state.ctrl.pixel_depth_code == 3'h4);
  assign mode_error             = state.mode_err;
endmodule // lpmc_control

//--- tb/lpmc_control_assertions.sv
`timescale 1ns/1ns
//------------------------------------------------------------
// Port-level checks of the mode and control bank
//------------------------------------------------------------
module lpmc_control_assertions (
  input wire logic       clk,                    // Clock
  input wire logic       resetn,                 // Reset
  input wire logic       avs_read,               // Read
  input wire logic       avs_write,              // Write
  input wire logic       avs_waitrequest,        // Stall
  input wire logic       dma_request,            // Refill
  input wire logic       vregion_start,          // Region pulse
  input wire logic       vertical_compare_event, // Event
  input wire logic       panel_power_pin,        // Supply
  input wire logic       controller_enable,      // Enable
  input wire logic       dual_panel,             // Dual
  input wire logic       mono_eight_bit,         // Mono 8
  input wire logic       panel_is_tft,           // TFT
  input wire logic       grayscaler_enable,      // Grayscaler
  input wire logic       stn_monochrome,         // Mono
  input wire logic [4:0] bits_per_pixel,         // Depth
  input wire logic       mode_error              // Bad mode
);
  import lpmc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // The pin is registered, so it may trail the enable flop by one cycle.
  property p_power; panel_power_pin |-> $past(controller_enable); endproperty
  a_power: assert property (p_power) else $error("power pin without enable");
  property p_dma; dma_request |-> $past(controller_enable); endproperty
  a_dma: assert property (p_dma) else $error("refill while disabled");
  property p_vc; vertical_compare_event |-> $past(vregion_start) && $past(controller_enable);
  endproperty
  a_vc: assert property (p_vc) else $error("compare event without cause");
  property p_ans; (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_m8; mono_eight_bit |-> stn_monochrome && !panel_is_tft; endproperty
  a_m8: assert property (p_m8) else $error("eight-bit mono outside mono STN");
  property p_gray; grayscaler_enable != panel_is_tft; endproperty
  a_gray: assert property (p_gray) else $error("grayscaler path wrong");
  property p_bpp; bits_per_pixel inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h0c}; endproperty
  a_bpp: assert property (p_bpp) else $error("depth decode out of range");
  property p_dual; dual_panel && !stn_monochrome |=> mode_error; endproperty
  a_dual: assert property (p_dual) else $error("dual colour not flagged");
  c_power: cover property (panel_power_pin);
  c_vc: cover property (vertical_compare_event);
  c_dma: cover property (dma_request);
endmodule // lpmc_control_assertions

//--- tb/lpmc_panel_model.sv
`timescale 1ns/1ns
//------------------------------------------------------------
// Panel timing and DMA FIFO side model
//------------------------------------------------------------
module lpmc_panel_model (
  input wire logic              clk,              // Clock
  input wire logic              resetn,           // Reset
  input wire logic [4:0]        upper_set,        // Upper empty level
  input wire logic [4:0]        lower_set,        // Lower empty level
  output logic [4:0]            fifo_upper_empty, // Upper empty count
  output logic [4:0]            fifo_lower_empty, // Lower empty count
  output logic                  vregion_start,    // Region pulse
  output lpmc_pkg::lpmc_vregion_t vregion_now     // Region entered
);
  import lpmc_pkg::*;
  logic [2:0] phase;
  // Regions advance every eight cycles, so each one recurs every 32.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 3'h0;
      vregion_start <= 1'b0;
      vregion_now <= LPMC_VC_VSYNC;
      fifo_upper_empty <= 5'h00;
      fifo_lower_empty <= 5'h00;
    end else begin
      phase <= phase + 3'h1;
      vregion_start <= (phase == 3'h7);
      if (phase == 3'h7) begin
        vregion_now <= lpmc_vregion_t'(vregion_now + 2'h1);
      end
      fifo_upper_empty <= upper_set;
      fifo_lower_empty <= lower_set;
    end
  end
endmodule // lpmc_panel_model

//--- tb/test_lcd_panel_mode_control.sv
`timescale 1ns/1ns
//------------------------------------------------------------
// Register-level bench of the mode and control bank
//------------------------------------------------------------
module test_lcd_panel_mode_control;
  import lpmc_pkg::*;
  logic clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, dma_request;
  logic vregion_start, vertical_compare_event, panel_power_pin, controller_enable;
  logic colour_order_swap, dual_panel, mono_eight_bit, panel_is_tft, grayscaler_enable;
  logic stn_monochrome, fetch_16bit, mode_error;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  logic [1:0] avs_response, rresp;
  logic [4:0] fifo_upper_empty, fifo_lower_empty, bits_per_pixel, upper_set = 0, lower_set = 8;
  lpmc_vregion_t vregion_now;
  int num_errors = 0, checks = 0, n;
  always #50 clk = ~clk;
  lpmc_control lpmc_control_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .fifo_upper_empty(fifo_upper_empty),
    .fifo_lower_empty(fifo_lower_empty), .dma_request(dma_request),
    .vregion_start(vregion_start), .vregion_now(vregion_now),
    .vertical_compare_event(vertical_compare_event), .panel_power_pin(panel_power_pin),
    .controller_enable(controller_enable), .colour_order_swap(colour_order_swap),
    .dual_panel(dual_panel), .mono_eight_bit(mono_eight_bit), .panel_is_tft(panel_is_tft),
    .grayscaler_enable(grayscaler_enable), .stn_monochrome(stn_monochrome),
    .bits_per_pixel(bits_per_pixel), .fetch_16bit(fetch_16bit), .mode_error(mode_error));
  lpmc_panel_model lpmc_panel_model_inst (.clk(clk), .resetn(resetn), .upper_set(upper_set),
    .lower_set(lower_set), .fifo_upper_empty(fifo_upper_empty),
    .fifo_lower_empty(fifo_lower_empty), .vregion_start(vregion_start),
    .vregion_now(vregion_now));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low, then lets outputs settle.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    rresp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic finish_test;
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  logic [4:0] bpp_tab [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h0c, 5'h00, 5'h00, 5'h00};
  logic [31:0] mode_wr [5] = '{32'h50, 32'h70, 32'h120, 32'h90, 32'h80};
  logic [6:0] mode_exp [5] = '{7'h16, 7'h0a, 7'h48, 7'h26, 7'h25};
  logic [31:0] pwr_wr [4] = '{32'h1, 32'h801, 32'h1, 32'h0};
  logic [41:0] wm_tab [5] = '{{32'h1, 5'd0, 5'd4}, {32'h1, 5'd3, 5'd3}, {32'h10001, 5'd0, 5'd7},
                              {32'h10001, 5'd8, 5'd0}, {32'h0, 5'd8, 5'd8}};
  logic [4:0] wm_exp = 5'b01001;
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    bus(0, 4'h0, 0);
    chk(rdata, 32'h0);
    chk({panel_power_pin, controller_enable, dma_request, grayscaler_enable}, 4'h1);
    bus(1, 4'h0, 32'hfffffffe);
    bus(0, 4'h0, 0);
    chk(rdata, 32'h0001b9fe);
    chk({panel_power_pin, mode_error, bits_per_pixel}, 7'h20);
    bus(0, 4'h4, 0);
    chk(rdata, 32'h00000048);
    bus(1, 4'h8, 0);
    bus(1, 4'hc, 32'h5a5aa5a5);
    bus(1, 4'h8, 0);
    bus(0, 4'hc, 0);
    chk({rresp, rdata}, {2'h0, 32'h5a5aa5a5});
    bus(1, 4'h0, 0);
    bus(0, 4'hc, 0);
    chk({rresp, rdata}, {2'h2, 32'h0});
    bus(0, 4'h2, 0);
    chk(rresp, 2'h2);
    for (int c = 0; c < 8; c++) begin
      bus(1, 4'h0, 32'(c) << 1);
      chk({fetch_16bit, bits_per_pixel}, {c == 4, bpp_tab[c]});
    end
    for (int i = 0; i < 5; i++) begin
      bus(1, 4'h0, mode_wr[i]);
      chk({colour_order_swap, dual_panel, mono_eight_bit, panel_is_tft, grayscaler_enable,
           stn_monochrome, mode_error}, mode_exp[i]);
    end
    // Panel delays are software's; the bench keeps only their order.
    for (int i = 0; i < 4; i++) begin
      bus(1, 4'h0, pwr_wr[i]);
      chk({controller_enable, panel_power_pin}, {i < 3, i == 1});
    end
    // Only the second byte lane is written; the other lanes must keep their value.
    avs_byteenable <= 4'h2;
    bus(1, 4'h0, 32'hffff31ff);
    avs_byteenable <= 4'hf;
    bus(0, 4'h0, 0);
    chk(rdata, 32'h00003100);
    chk(colour_order_swap, 1'b1);
    for (int i = 0; i < 5; i++) begin
      upper_set <= wm_tab[i][9:5];
      lower_set <= wm_tab[i][4:0];
      bus(1, 4'h0, wm_tab[i][41:10]);
      chk(dma_request, wm_exp[i]);
    end
    for (int s = 0; s < 5; s++) begin
      bus(1, 4'h0, (s < 4) ? (32'h1 | (32'(s) << 12)) : 32'h0);
      n = 0;
      repeat (32) begin
        @(posedge clk);
        if (vertical_compare_event === 1'b1) begin
          n++;
          chk(vregion_now, s);
        end
      end
      chk(n, s < 4);
    end
    finish_test();
  end
endmodule // test_lcd_panel_mode_control
bind lpmc_control lpmc_control_assertions lpmc_control_assertions_inst (.clk(clk),
  .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .dma_request(dma_request), .vregion_start(vregion_start),
  .vertical_compare_event(vertical_compare_event), .panel_power_pin(panel_power_pin),
  .controller_enable(controller_enable), .dual_panel(dual_panel),
  .mono_eight_bit(mono_eight_bit), .panel_is_tft(panel_is_tft),
  .grayscaler_enable(grayscaler_enable), .stn_monochrome(stn_monochrome),
  .bits_per_pixel(bits_per_pixel), .mode_error(mode_error));
